// file: tcm_byte_store.sv
`timescale 1ns/1ps
// Little store for the stored (non-volatile image) configuration bytes
module tcm_byte_store
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Registered read port
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data
);

  typedef struct packed {
    logic [TCM_NUM_BYTES-1:0][7:0] mem;
    logic [7:0] rd;
  } tcm_store_t;

  tcm_store_t s_q;
  tcm_store_t s_d;

  // Write and registered read; a same-cycle read of the written byte returns its old value
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.mem[wr_idx] = wr_data;
    end
    s_d.rd = s_q.mem[rd_idx];
  end

  // Stored image starts at the documented defaults
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.mem[TCM_IDX_CFG_ONE] <= TCM_RST_CFG_ONE;
      s_q.mem[TCM_IDX_CFG_TWO] <= TCM_RST_CFG_TWO;
      s_q.mem[TCM_IDX_MASK_ZERO] <= TCM_RST_MASK;
      s_q.mem[TCM_IDX_MASK_ONE] <= TCM_RST_MASK;
      s_q.rd <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd;

endmodule

// file: tcm_config_bank.sv
`timescale 1ns/1ps
// Functional notes
// - Receive-CRC retention bit keeps CRC bytes in buffer during tunneling.
// - With CRC retention, longest usable payload shrinks to thirty bytes.
// - Received frame CRC is always checked, independent of retention bit.
// - First byte: regulator voltage bits 6..2, resistance bits 1..0, default zero.
// - Host always accesses bytes; RF only while RF-configuration enable is one.
// - Second byte bit 7 is RF-configuration enable, defaulting to one.
// - RF-configuration enable zero refuses RF writes to last two blocks.
// - Tunneling and extended enables seed volatile copies the host may change.
// - Both tunneling and extended enabled means tunneling mode.
// - Neither enabled means standalone; all RF commands go to EEPROM.
// - Mode change is accepted at any moment, no reset or idle needed.
// - Anti-collision is identical in all modes; only selected behaviour differs.
// - Bit 4 selects the error-response policy for CRC and parity errors.
// - Bit 3 lets RF change auth limits and permissions after authentication.
// - Authenticated RF side may always change the password.
// - Bit 2 inverts bit 6 of cascade-level-2 reply byte.
// - Power mode: 00 default, 01 field only, 10 companion, 11 external.
// - Two stored mask bytes seed the two volatile interrupt mask registers.
module tcm_config_bank
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host (SPI or I2C) access to stored bytes
  input wire tcm_pkg::tcm_acc_t host_cfg,
  output logic host_cfg_ack,
  output logic [7:0] host_cfg_rdata,
  // Host access to volatile copies
  input wire tcm_pkg::tcm_acc_t host_vol,
  output logic host_vol_ack,
  output logic [7:0] host_vol_rdata,
  // RF reader access to stored bytes
  input wire tcm_pkg::tcm_acc_t rf_cfg,
  output logic rf_cfg_ack,
  output logic rf_cfg_refused,
  output logic [7:0] rf_cfg_rdata,
  // RF memory write permission checks
  input wire logic rf_blk_wr,
  input wire logic [7:0] rf_blk_addr,
  input wire logic rf_blk_is_auth_cfg,
  input wire logic rf_blk_is_password,
  input wire logic tag_authenticated,
  input wire logic perm_allows_wr,
  output logic rf_blk_wr_ok,
  // Received frame checking
  input wire logic rx_frame_done,
  input wire logic rx_crc_ok,
  input wire logic rx_parity_ok,
  output logic rx_err,
  output logic rx_send_nak,
  output logic rx_keep_crc,
  // Cascade-level reply
  input wire logic [7:0] sel_res_cfg,
  input wire logic cascade_two,
  input wire logic tag_selected,
  output logic [7:0] sel_res_out,
  output logic mode_applies,
  output logic rf_to_eeprom,
  // Decoded configuration
  output tcm_pkg::tcm_cfg_t cfg,
  output logic cfg_ready
);

  typedef struct packed {
    tcm_state_t st;
    logic [1:0] load_idx;
    logic load_wait;
    logic [7:0] vol_one;
    logic [7:0] vol_two;
    logic [7:0] vol_mask_zero;
    logic [7:0] vol_mask_one;
    logic tun_en;
    logic ext_en;
    logic host_ack;
    logic host_vack;
    logic [7:0] host_vrd;
    logic rf_ack;
    logic rf_ref;
    logic err;
    logic nak;
    logic [1:0] rd_owner;
  } tcm_state_s_t;

  localparam logic [1:0] OWN_NONE = 2'h0;
  localparam logic [1:0] OWN_HOST = 2'h1;
  localparam logic [1:0] OWN_RF = 2'h2;

  tcm_state_s_t s_q;
  tcm_state_s_t s_d;

  logic st_wr;
  logic [1:0] st_wr_idx;
  logic [7:0] st_wr_data;
  logic [1:0] st_rd_idx;
  logic [7:0] st_rd_data;
  logic running;
  logic rf_allowed;
  tcm_mode_t mode_sel;

  assign running = (s_q.st == TCM_ST_RUN);
  assign rf_allowed = s_q.vol_two[TCM_B2_RFCFG];

  // Store arbitration: host wins a same-cycle clash, RF retries
  always_comb begin
    st_wr = 1'b0;
    st_wr_idx = host_cfg.idx;
    st_wr_data = host_cfg.wdata;
    st_rd_idx = s_q.load_idx;
    if (running) begin
      if (host_cfg.req) begin
        st_wr = host_cfg.wr;
        st_rd_idx = host_cfg.idx;
      end else if (rf_cfg.req && rf_allowed) begin
        st_wr = rf_cfg.wr;
        st_wr_idx = rf_cfg.idx;
        st_wr_data = rf_cfg.wdata;
        st_rd_idx = rf_cfg.idx;
      end
    end
  end

  tcm_byte_store u_store (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(st_wr),
    .wr_idx(st_wr_idx),
    .wr_data(st_wr_data),
    .rd_idx(st_rd_idx),
    .rd_data(st_rd_data)
  );

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.host_ack = 1'b0;
    s_d.host_vack = 1'b0;
    s_d.rf_ack = 1'b0;
    s_d.rf_ref = 1'b0;
    s_d.rd_owner = OWN_NONE;
    unique case (s_q.st)
      // Copy stored image to volatile registers before serving anyone
      TCM_ST_LOAD: begin
        s_d.load_wait = 1'b1;
        if (s_q.load_wait) begin
          unique case (s_q.load_idx)
            TCM_IDX_CFG_ONE: s_d.vol_one = st_rd_data;
            TCM_IDX_CFG_TWO: begin
              s_d.vol_two = st_rd_data;
              s_d.tun_en = st_rd_data[TCM_B2_TUN];
              s_d.ext_en = st_rd_data[TCM_B2_EXT];
            end
            TCM_IDX_MASK_ZERO: s_d.vol_mask_zero = st_rd_data;
            TCM_IDX_MASK_ONE: s_d.vol_mask_one = st_rd_data;
          endcase
          s_d.load_wait = 1'b0;
          if (s_q.load_idx == TCM_IDX_MASK_ONE) begin
            s_d.st = TCM_ST_RUN;
          end else begin
            s_d.load_idx = s_q.load_idx + 2'h1;
          end
        end
      end
      // Serve host and RF; stored byte writes reach the live copies at once, except the tunneling and extended enables
      TCM_ST_RUN: begin
        if (host_cfg.req) begin
          s_d.host_ack = 1'b1;
          s_d.rd_owner = OWN_HOST;
        end else if (rf_cfg.req) begin
          if (rf_allowed) begin
            s_d.rf_ack = 1'b1;
            s_d.rd_owner = OWN_RF;
          end else begin
            s_d.rf_ref = 1'b1;
          end
        end
        if (st_wr) begin
          unique case (st_wr_idx)
            TCM_IDX_CFG_ONE: s_d.vol_one = st_wr_data;
            TCM_IDX_CFG_TWO: s_d.vol_two = st_wr_data;
            TCM_IDX_MASK_ZERO: s_d.vol_mask_zero = st_wr_data;
            TCM_IDX_MASK_ONE: s_d.vol_mask_one = st_wr_data;
          endcase
        end
        // Host may retune the live copies; mode may change any time
        if (host_vol.req) begin
          s_d.host_vack = 1'b1;
          if (host_vol.wr) begin
            unique case (host_vol.idx)
              TCM_IDX_CFG_ONE: s_d.vol_one = host_vol.wdata;
              TCM_IDX_CFG_TWO: begin
                s_d.vol_two = host_vol.wdata;
                s_d.tun_en = host_vol.wdata[TCM_B2_TUN];
                s_d.ext_en = host_vol.wdata[TCM_B2_EXT];
              end
              TCM_IDX_MASK_ZERO: s_d.vol_mask_zero = host_vol.wdata;
              TCM_IDX_MASK_ONE: s_d.vol_mask_one = host_vol.wdata;
            endcase
          end
          unique case (host_vol.idx)
            TCM_IDX_CFG_ONE: s_d.host_vrd = s_q.vol_one;
            TCM_IDX_CFG_TWO: begin
              s_d.host_vrd = s_q.vol_two;
              s_d.host_vrd[TCM_B2_TUN] = s_q.tun_en;
              s_d.host_vrd[TCM_B2_EXT] = s_q.ext_en;
            end
            TCM_IDX_MASK_ZERO: s_d.host_vrd = s_q.vol_mask_zero;
            TCM_IDX_MASK_ONE: s_d.host_vrd = s_q.vol_mask_one;
          endcase
        end
      end
      default: s_d.st = TCM_ST_LOAD;
    endcase
    // Frame check runs in every mode
    s_d.err = 1'b0;
    s_d.nak = 1'b0;
    if (rx_frame_done && !(rx_crc_ok && rx_parity_ok)) begin
      s_d.err = 1'b1;
      s_d.nak = s_q.vol_two[TCM_B2_NAK];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.st <= TCM_ST_LOAD;
      s_q.load_idx <= TCM_IDX_CFG_ONE;
      s_q.load_wait <= 1'b0;
      s_q.vol_one <= TCM_RST_CFG_ONE;
      s_q.vol_two <= TCM_RST_CFG_TWO;
      s_q.vol_mask_zero <= TCM_RST_MASK;
      s_q.vol_mask_one <= TCM_RST_MASK;
      s_q.tun_en <= 1'b0;
      s_q.ext_en <= 1'b0;
      s_q.host_ack <= 1'b0;
      s_q.host_vack <= 1'b0;
      s_q.host_vrd <= 8'h00;
      s_q.rf_ack <= 1'b0;
      s_q.rf_ref <= 1'b0;
      s_q.err <= 1'b0;
      s_q.nak <= 1'b0;
      s_q.rd_owner <= OWN_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answers
  assign host_cfg_ack = s_q.host_ack;
  assign host_cfg_rdata = (s_q.rd_owner == OWN_HOST) ? st_rd_data : 8'h00;
  assign host_vol_ack = s_q.host_vack;
  assign host_vol_rdata = s_q.host_vrd;
  assign rf_cfg_ack = s_q.rf_ack;
  assign rf_cfg_refused = s_q.rf_ref;
  assign rf_cfg_rdata = (s_q.rd_owner == OWN_RF) ? st_rd_data : 8'h00;
  assign cfg_ready = running;
  assign rx_err = s_q.err;
  assign rx_send_nak = s_q.nak;

  // RF memory write permission
  always_comb begin
    rf_blk_wr_ok = 1'b0;
    if (rf_blk_wr && running) begin
      if (rf_blk_is_password) begin
        rf_blk_wr_ok = tag_authenticated;
      end else if (rf_blk_is_auth_cfg) begin
        rf_blk_wr_ok = tag_authenticated && s_q.vol_two[TCM_B2_AUTH];
      end else if (rf_blk_addr >= TCM_LAST_BLOCKS_FROM) begin
        rf_blk_wr_ok = rf_allowed && perm_allows_wr;
      end else begin
        rf_blk_wr_ok = perm_allows_wr;
      end
    end
  end

  // Mode decode: tunneling beats extended; kept apart so cfg has only plain drivers
  always_comb begin
    mode_sel = TCM_MODE_STANDALONE;
    if (s_q.tun_en) begin
      mode_sel = TCM_MODE_TUNNEL;
    end else if (s_q.ext_en) begin
      mode_sel = TCM_MODE_EXTENDED;
    end
  end
  assign cfg.mode = mode_sel;

  // Modes only matter once selected; anti-collision is shared
  assign mode_applies = tag_selected && (cfg.mode != TCM_MODE_STANDALONE);
  assign rf_to_eeprom = (cfg.mode == TCM_MODE_STANDALONE);

  // CRC retention only in tunneling mode, costing two payload bytes
  assign rx_keep_crc = s_q.vol_one[TCM_B1_RX_CRC] && (cfg.mode == TCM_MODE_TUNNEL);
  assign cfg.keep_rx_crc = rx_keep_crc;
  assign cfg.max_payload = rx_keep_crc ? TCM_MAX_PAYLOAD_CRC : TCM_MAX_PAYLOAD;

  // Field decode
  assign cfg.vreg = s_q.vol_one[TCM_B1_VREG_HI:TCM_B1_VREG_LO];
  assign cfg.rreg = s_q.vol_one[TCM_B1_RREG_HI:TCM_B1_RREG_LO];
  assign cfg.rf_cfg_en = rf_allowed;
  assign cfg.nak_on_err = s_q.vol_two[TCM_B2_NAK];
  assign cfg.auth_set = s_q.vol_two[TCM_B2_AUTH];
  assign cfg.selres_flip = s_q.vol_two[TCM_B2_SELINV];
  assign cfg.powm = tcm_powm_t'(s_q.vol_two[TCM_B2_POWM_HI:TCM_B2_POWM_LO]);
  assign cfg.irq_mask_zero = s_q.vol_mask_zero;
  assign cfg.irq_mask_one = s_q.vol_mask_one;

  tcm_selres_flip u_selres (
    .sel_res_cfg(sel_res_cfg),
    .cascade_two(cascade_two),
    .flip_en(s_q.vol_two[TCM_B2_SELINV]),
    .sel_res_out(sel_res_out)
  );

endmodule

// file: tcm_config_bank_props.sv
`timescale 1ns/1ps
// Port-level checks for the configuration bank
module tcm_config_bank_props
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Stored byte access
  input wire tcm_pkg::tcm_acc_t host_cfg,
  input wire logic host_cfg_ack,
  input wire tcm_pkg::tcm_acc_t rf_cfg,
  input wire logic rf_cfg_ack,
  input wire logic rf_cfg_refused,
  // Block writes and frames
  input wire logic rf_blk_wr,
  input wire logic [7:0] rf_blk_addr,
  input wire logic rf_blk_is_password,
  input wire logic tag_authenticated,
  input wire logic rf_blk_wr_ok,
  input wire logic rx_frame_done,
  input wire logic rx_crc_ok,
  input wire logic rx_parity_ok,
  input wire logic rx_err,
  input wire logic rx_send_nak,
  input wire logic rx_keep_crc,
  // Reply and decoded configuration
  input wire logic [7:0] sel_res_cfg,
  input wire logic cascade_two,
  input wire logic [7:0] sel_res_out,
  input wire logic rf_to_eeprom,
  input wire tcm_pkg::tcm_cfg_t cfg,
  input wire logic cfg_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Host wins a same-cycle clash, so RF takes count only without a host request
  sequence s_host_take;
    host_cfg.req && cfg_ready;
  endsequence
  sequence s_rf_open;
    rf_cfg.req && cfg_ready && !host_cfg.req && cfg.rf_cfg_en;
  endsequence
  sequence s_rf_shut;
    rf_cfg.req && cfg_ready && !host_cfg.req && !cfg.rf_cfg_en;
  endsequence
  chk_host_ack_next: assert property (s_host_take |=> host_cfg_ack)
    else $error("host access not answered");
  chk_load_first: assert property (!cfg_ready |=> !host_cfg_ack && !rf_cfg_ack)
    else $error("answer before load complete");
  chk_rf_grant: assert property (s_rf_open |=> rf_cfg_ack && !rf_cfg_refused)
    else $error("rf access not granted");
  chk_rf_refuse: assert property (s_rf_shut |=> rf_cfg_refused && !rf_cfg_ack)
    else $error("rf access not refused");
  chk_rx_err: assert property (rx_frame_done && !(rx_crc_ok && rx_parity_ok) |=> rx_err)
    else $error("frame error not flagged");
  chk_nak_policy: assert property (rx_frame_done && !(rx_crc_ok && rx_parity_ok)
    |=> rx_send_nak == $past(cfg.nak_on_err))
    else $error("error response policy wrong");
  chk_no_keep: assert property (cfg.mode != TCM_MODE_TUNNEL |-> !rx_keep_crc
    && cfg.max_payload == TCM_MAX_PAYLOAD)
    else $error("crc kept outside tunneling");
  chk_keep_crc: assert property (cfg.mode == TCM_MODE_TUNNEL |-> rx_keep_crc == cfg.keep_rx_crc
    && cfg.max_payload == (cfg.keep_rx_crc ? 6'h1E : 6'h20))
    else $error("crc keep or payload limit wrong");
  chk_sel_flip: assert property (cascade_two |-> sel_res_out[6] == (sel_res_cfg[6] ^ cfg.selres_flip))
    else $error("reply bit 6 wrong");
  chk_blk_lock: assert property (rf_blk_wr && rf_blk_addr >= 8'hFE && !cfg.rf_cfg_en
    |-> !rf_blk_wr_ok)
    else $error("locked block write allowed");
  chk_pw_auth: assert property (rf_blk_wr && rf_blk_is_password && tag_authenticated
    && rf_blk_addr < 8'hFE |-> rf_blk_wr_ok)
    else $error("password write refused");
  chk_standalone: assert property (cfg.mode == TCM_MODE_STANDALONE |-> rf_to_eeprom)
    else $error("standalone not routed to memory");
endmodule
bind tcm_config_bank tcm_config_bank_props u_props (.ref_clk, .rst_n, .host_cfg, .host_cfg_ack,
  .rf_cfg, .rf_cfg_ack, .rf_cfg_refused, .rf_blk_wr, .rf_blk_addr, .rf_blk_is_password,
  .tag_authenticated, .rf_blk_wr_ok, .rx_frame_done, .rx_crc_ok, .rx_parity_ok, .rx_err, .rx_send_nak,
  .rx_keep_crc, .sel_res_cfg, .cascade_two, .sel_res_out, .rf_to_eeprom, .cfg, .cfg_ready);

// file: tcm_config_bank_tb.sv
`timescale 1ns/1ps
module tcm_config_bank_tb;
  import tcm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  tcm_acc_t host_cfg, host_vol, rf_cfg;
  tcm_cfg_t cfg;
  logic hc_ack, hv_ack, rc_ack, rc_ref, blk_ok, rx_err, keep, to_ee, cfg_ready, got, refd;
  logic [7:0] hc_rd, hv_rd, rc_rd, sel_out, rd;
  logic blk_wr = 1'b0, blk_auth = 1'b0, blk_pw = 1'b0, authd = 1'b0, perm = 1'b0;
  logic done = 1'b0, crc_ok = 1'b1, par_ok = 1'b1, casc = 1'b0, sel_tag = 1'b1, nak, mode_on;
  logic [7:0] blk_addr = 8'h00, sel_cfg = 8'h00;
  logic [7:0] pat [4] = '{8'hA5, 8'hBC, 8'h3C, 8'hC3};
  int failures = 0, tests_run = 0, cyc = 0;
  // 100 MHz reference
  always #5 ref_clk = ~ref_clk;
  tcm_config_bank uut (.ref_clk, .rst_n, .host_cfg, .host_cfg_ack(hc_ack),
    .host_cfg_rdata(hc_rd), .host_vol, .host_vol_ack(hv_ack), .host_vol_rdata(hv_rd),
    .rf_cfg, .rf_cfg_ack(rc_ack), .rf_cfg_refused(rc_ref), .rf_cfg_rdata(rc_rd),
    .rf_blk_wr(blk_wr), .rf_blk_addr(blk_addr), .rf_blk_is_auth_cfg(blk_auth),
    .rf_blk_is_password(blk_pw), .tag_authenticated(authd), .perm_allows_wr(perm),
    .rf_blk_wr_ok(blk_ok), .rx_frame_done(done), .rx_crc_ok(crc_ok), .rx_parity_ok(par_ok),
    .rx_err, .rx_send_nak(nak), .rx_keep_crc(keep), .sel_res_cfg(sel_cfg), .cascade_two(casc),
    .tag_selected(sel_tag), .sel_res_out(sel_out), .mode_applies(mode_on), .rf_to_eeprom(to_ee),
    .cfg, .cfg_ready);
  tcm_far_model u_hc (.ref_clk, .ack(hc_ack), .refused(1'b0), .rdata(hc_rd), .acc(host_cfg));
  tcm_far_model u_hv (.ref_clk, .ack(hv_ack), .refused(1'b0), .rdata(hv_rd), .acc(host_vol));
  tcm_far_model u_rc (.ref_clk, .ack(rc_ack), .refused(rc_ref), .rdata(rc_rd), .acc(rf_cfg));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic hw(input logic [1:0] i, input logic [7:0] d);
    u_hc.xfer(1'b1, i, d, rd, got, refd);
  endtask
  task automatic hr(input logic [1:0] i, input logic [7:0] e);
    u_hc.xfer(1'b0, i, 8'h00, rd, got, refd);
    chk(rd, e);
    chk(8'(got), 8'h01);
  endtask
  task automatic vw(input logic [1:0] i, input logic [7:0] d);
    u_hv.xfer(1'b1, i, d, rd, got, refd);
  endtask
  // Block write permission probe, comb answer
  task automatic blk(input logic [7:0] a, input logic [2:0] f, input logic e);
    blk_wr <= 1'b1;
    blk_addr <= a;
    {blk_pw, blk_auth, perm} <= f;
    authd <= 1'b1;
    @(posedge ref_clk);
    chk(8'(blk_ok), 8'(e));
  endtask
  // Hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    chk(8'(cfg.rf_cfg_en), 8'h01);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(8'(cfg_ready), 8'h00);
    repeat (9) @(posedge ref_clk);
    chk(8'(cfg_ready), 8'h01);
    for (int i = 0; i < 4; i++) begin
      hr(2'(i), i == 1 ? 8'h80 : 8'h00);
    end
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      hw(2'(i), pat[i]);
    end
    for (int i = 0; i < 4; i++) begin
      hr(2'(i), pat[i]);
    end
    chk(8'(cfg.vreg), 8'h09);
    chk(8'(cfg.rreg), 8'h01);
    chk(8'(cfg.mode), 8'h00);
    chk({cfg.nak_on_err, cfg.auth_set, cfg.selres_flip, 5'h00}, 8'hE0);
    chk(cfg.irq_mask_zero, 8'h3C);
    chk(cfg.irq_mask_one, 8'hC3);
    u_hv.xfer(1'b0, 2'h1, 8'h00, rd, got, refd);
    chk(rd, 8'h9C);
    $display("test bytes done");
    // Mode changes on the fly, no reset between them
    for (int m = 0; m < 4; m++) begin
      vw(2'h1, 8'h9C | 8'(m << 5));
      chk(8'(cfg.mode), m[1] ? 8'h01 : 8'(m * 2));
      chk(8'(to_ee), 8'(m == 0));
      chk(8'(keep), 8'(m[1]));
      chk(8'(cfg.max_payload), m[1] ? 8'h1E : 8'h20);
      chk(8'(mode_on), 8'(m != 0));
    end
    sel_tag <= 1'b0;
    @(posedge ref_clk);
    chk(8'(mode_on), 8'h00);
    sel_tag <= 1'b1;
    $display("test modes done");
    for (int p = 0; p < 4; p++) begin
      hw(2'h1, 8'h84 | 8'(p));
      sel_cfg <= {1'b0, p[0], 6'h00};
      casc <= 1'b1;
      @(posedge ref_clk);
      chk(8'(cfg.powm), 8'(p));
      chk(8'(sel_out[6]), p[0] ? 8'h00 : 8'h01);
    end
    chk(8'(cfg.nak_on_err), 8'h00);
    $display("test power done");
    u_rc.xfer(1'b0, 2'h0, 8'h00, rd, got, refd);
    chk(rd, 8'hA5);
    u_rc.xfer(1'b1, 2'h2, 8'h11, rd, got, refd);
    hr(2'h2, 8'h11);
    hw(2'h1, 8'h00);
    vw(2'h1, 8'h00);
    u_rc.xfer(1'b1, 2'h2, 8'h22, rd, got, refd);
    chk({got, refd, 6'h00}, 8'h40);
    hr(2'h2, 8'h11);
    blk(8'hFE, 3'b001, 1'b0);
    blk(8'h10, 3'b001, 1'b1);
    blk(8'h10, 3'b100, 1'b1);
    blk(8'h10, 3'b010, 1'b0);
    hw(2'h1, 8'h08);
    blk(8'h10, 3'b010, 1'b1);
    blk_wr <= 1'b0;
    $display("test rf done");
    // Both error kinds, retention bit clear then set, in standalone mode so crc is never kept
    for (int k = 0; k < 2; k++) begin
      hw(2'h0, k[0] ? 8'h80 : 8'h00);
      hw(2'h1, k[0] ? 8'h18 : 8'h08);
      crc_ok <= k[0];
      par_ok <= !k[0];
      done <= 1'b1;
      @(posedge ref_clk);
      done <= 1'b0;
      crc_ok <= 1'b1;
      par_ok <= 1'b1;
      @(posedge ref_clk);
      chk(8'(rx_err), 8'h01);
      chk(8'(nak), 8'(k[0]));
    end
    $display("test frames done");
    final_report();
  end
endmodule

// file: tcm_far_model.sv
`timescale 1ns/1ps
// Far-side requester, used for the host and for the RF reader
module tcm_far_model
  import tcm_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Answer from the bank
  input wire logic ack,
  input wire logic refused,
  input wire logic [7:0] rdata,
  // Request to the bank
  output tcm_pkg::tcm_acc_t acc
);
  initial acc = '0;
  // Holds the request until answered or refused, at most six cycles; idle data is inverted so it never looks valid
  task automatic xfer(input logic w, input logic [1:0] i, input logic [7:0] d,
                      output logic [7:0] rd, output logic got, output logic refd);
    int n;
    n = 0;
    acc <= '{1'b1, w, i, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && refused !== 1'b1 && n < 6);
    got = ack;
    refd = refused;
    rd = rdata;
    acc <= '{1'b0, 1'b0, 2'h0, ~d};
    @(posedge ref_clk);
  endtask
endmodule

// file: tcm_pkg.sv
package tcm_pkg;

  // Configuration byte indices within the bank
  localparam logic [1:0] TCM_IDX_CFG_ONE = 2'h0;
  localparam logic [1:0] TCM_IDX_CFG_TWO = 2'h1;
  localparam logic [1:0] TCM_IDX_MASK_ZERO = 2'h2;
  localparam logic [1:0] TCM_IDX_MASK_ONE = 2'h3;
  localparam int TCM_NUM_BYTES = 4;

  // Field positions, first configuration byte
  localparam int TCM_B1_RX_CRC = 7;
  localparam int TCM_B1_VREG_HI = 6;
  localparam int TCM_B1_VREG_LO = 2;
  localparam int TCM_B1_RREG_HI = 1;
  localparam int TCM_B1_RREG_LO = 0;

  // Field positions, second configuration byte
  localparam int TCM_B2_RFCFG = 7;
  localparam int TCM_B2_TUN = 6;
  localparam int TCM_B2_EXT = 5;
  localparam int TCM_B2_NAK = 4;
  localparam int TCM_B2_AUTH = 3;
  localparam int TCM_B2_SELINV = 2;
  localparam int TCM_B2_POWM_HI = 1;
  localparam int TCM_B2_POWM_LO = 0;
  localparam int TCM_SELRES_B6 = 6;

  // Values after reset
  localparam logic [7:0] TCM_RST_CFG_ONE = 8'h00;
  localparam logic [7:0] TCM_RST_CFG_TWO = 8'h80;
  localparam logic [7:0] TCM_RST_MASK = 8'h00;

  // Payload limits in bytes
  localparam logic [5:0] TCM_MAX_PAYLOAD = 6'h20;
  localparam logic [5:0] TCM_MAX_PAYLOAD_CRC = 6'h1E;
  localparam logic [5:0] TCM_CRC_BYTES = 6'h02;

  // Memory block protection: last two blocks of the array
  localparam logic [7:0] TCM_LAST_BLOCKS_FROM = 8'hFE;

  typedef enum logic [1:0] {
    TCM_MODE_STANDALONE = 2'b00,
    TCM_MODE_TUNNEL = 2'b01,
    TCM_MODE_EXTENDED = 2'b10
  } tcm_mode_t;

  typedef enum logic [1:0] {
    TCM_POW_DEFAULT = 2'b00,
    TCM_POW_FIELD = 2'b01,
    TCM_POW_COMPANION = 2'b10,
    TCM_POW_EXTERNAL = 2'b11
  } tcm_powm_t;

  typedef enum logic [1:0] {
    TCM_ST_LOAD = 2'b00,
    TCM_ST_RUN = 2'b01
  } tcm_state_t;

  // One byte access request
  typedef struct packed {
    logic req;
    logic wr;
    logic [1:0] idx;
    logic [7:0] wdata;
  } tcm_acc_t;

  // Decoded configuration seen by the rest of the tag
  typedef struct packed {
    logic keep_rx_crc;
    logic [4:0] vreg;
    logic [1:0] rreg;
    logic rf_cfg_en;
    logic nak_on_err;
    logic auth_set;
    logic selres_flip;
    tcm_powm_t powm;
    tcm_mode_t mode;
    logic [5:0] max_payload;
    logic [7:0] irq_mask_zero;
    logic [7:0] irq_mask_one;
  } tcm_cfg_t;

endpackage

// file: tcm_selres_flip.sv
`timescale 1ns/1ps
// Builds the cascade-level reply byte with optional bit 6 flip
module tcm_selres_flip
  import tcm_pkg::*;
(
  // Inputs
  input wire logic [7:0] sel_res_cfg,
  input wire logic cascade_two,
  input wire logic flip_en,
  // Output
  output logic [7:0] sel_res_out
);

  // Flip applies only on the second cascade level
  always_comb begin
    sel_res_out = sel_res_cfg;
    if (cascade_two && flip_en) begin
      sel_res_out[TCM_SELRES_B6] = ~sel_res_cfg[TCM_SELRES_B6];
    end
  end

endmodule
